// >>> include/mais_regs.svh
// command codes, field positions, cause widths and reset values
// assumes inclusion by the main module, the command decoder and the bench
`ifndef MAIS_REGS_SVH
`define MAIS_REGS_SVH

// command codes
`define MAIS_CMD_STOP_IRQ_RESET   16'h0008
`define MAIS_CMD_READ_ERROR       16'h00f2
`define MAIS_CMD_READ_EVENT       16'h00f3
`define MAIS_CMD_WRITE_ENABLE     16'h00ac
`define MAIS_CMD_WRITE_ERROR      16'h00ad
`define MAIS_CMD_WRITE_EVENT      16'h00ae

// main status bit positions
`define MAIS_MSTS_SUMMARY         0
`define MAIS_MSTS_STOP            1
`define MAIS_MSTS_ERROR           2
`define MAIS_MSTS_EVENT           3

// cause register widths and reserved bits
`define MAIS_CAUSE_BITS           23
`define MAIS_ERROR_RSVD_BIT       11
`define MAIS_EVENT_BITS           17
`define MAIS_ERROR_VALID_MASK     23'h7ff7ff
`define MAIS_EVENT_VALID_MASK     23'h01ffff

// reset values
`define MAIS_ENABLE_RESET         32'h00000000
`define MAIS_CAUSE_RESET          23'h000000

`endif

// >>> include/mais_pkg.sv
// types shared by the interrupt status block and its command decoder
// assumes mais_regs.svh constants
package mais_pkg;

    // decoded command strobes
    typedef struct packed {
        logic stop_reset;
        logic read_error;
        logic read_event;
        logic write_enable;
        logic write_error;
        logic write_event;
    } mais_cmd_s;

    // mode configuration bits held by the axis
    typedef struct packed {
        logic irq_request_mask;
        logic stop_to_request_disable;
        logic prereg_stop_irq_disable;
        logic auto_stop_irq_reset;
        logic auto_cause_reset_off;
    } mais_cfg_s;

    // command access type seen on the command port
    typedef enum logic [1:0] {
        MAIS_ACC_IDLE,
        MAIS_ACC_WRITE,
        MAIS_ACC_READ
    } mais_acc_e;

endpackage

// >>> logic/mais_cmd_decode.sv
// decodes command codes into one-cycle strobes for the interrupt block
// assumes a command code valid for one cycle with its strobe
`timescale 1ns/1ps
`include "mais_regs.svh"

module mais_cmd_decode
    import mais_pkg::*;
(
    // command
    input  wire logic [15:0] code,
    input  wire logic        valid,
    // strobes
    output mais_cmd_s        cmd
);

    always_comb
    begin
        cmd              = '0;
        cmd.stop_reset   = valid && (code == `MAIS_CMD_STOP_IRQ_RESET);
        cmd.read_error   = valid && (code == `MAIS_CMD_READ_ERROR);
        cmd.read_event   = valid && (code == `MAIS_CMD_READ_EVENT);
        cmd.write_enable = valid && (code == `MAIS_CMD_WRITE_ENABLE);
        cmd.write_error  = valid && (code == `MAIS_CMD_WRITE_ERROR);
        cmd.write_event  = valid && (code == `MAIS_CMD_WRITE_EVENT);
    end

endmodule

// >>> logic/mais_top.sv
// interrupt status and control of one motion axis node
// assumes commands arrive from the network link logic on CLK,
// cause pulses come from axis logic on CLK, config bits from mode regs
`timescale 1ns/1ps
`include "mais_regs.svh"

module mais_top
    import mais_pkg::*;
(
    // clock and reset
    input  wire logic        CLK,
    input  wire logic        RST,
    input  wire logic        CE,
    // command port
    input  wire logic [15:0] CMD_CODE,
    input  wire logic        CMD_VALID,
    input  wire logic [31:0] CMD_WDATA,
    output logic      [31:0] CMD_RDATA,
    output logic             CMD_RVALID,
    // mode bits
    input  mais_cfg_s        CFG,
    // axis events, one-cycle pulses
    input  wire logic        STOP_EVENT,
    input  wire logic        PREREG_FIXED,
    input  wire logic        START_CMD,
    input  wire logic [22:0] ERROR_SRC,
    input  wire logic [22:0] EVENT_SRC,
    // status
    output logic      [7:0]  MAIN_STATUS,
    output logic             SUMMARY_IRQ_REQUEST
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic        stop_flag;
        logic [22:0] error_cause;
        logic [22:0] event_cause;
        logic [31:0] event_enable;
        logic [31:0] rdata;
        logic        rvalid;
    } mais_state_s;

    mais_state_s state;
    mais_state_s next_state;
    mais_cmd_s   cmd;
    logic        error_irq_flag;
    logic        event_irq_flag;
    logic        summary;

    mais_cmd_decode u_decode
    (
        .code  (CMD_CODE),
        .valid (CMD_VALID),
        .cmd   (cmd)
    );

    // clear mask from a write: ones clear, zeros keep
    function automatic logic [22:0] w1c(input logic [22:0] cur, input logic [31:0] wd);
        w1c = cur & ~wd[22:0];
    endfunction

    // ------------------------------------------------------------
    // status flags and summary
    // ------------------------------------------------------------
    // error and event pending flags
    assign error_irq_flag = |state.error_cause;
    assign event_irq_flag = |state.event_cause;

    assign summary = !CFG.irq_request_mask &&
                     ((state.stop_flag && !CFG.stop_to_request_disable) ||
                      error_irq_flag || event_irq_flag);

    assign SUMMARY_IRQ_REQUEST = summary;
    assign MAIN_STATUS = {4'h0, event_irq_flag, error_irq_flag, state.stop_flag, summary};
    assign CMD_RDATA   = state.rdata;
    assign CMD_RVALID  = state.rvalid;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        logic [22:0] err_set;
        logic [22:0] evt_set;
        logic [22:0] err_keep;
        logic [22:0] evt_keep;
        err_set  = '0;
        evt_set  = '0;
        err_keep = '0;
        evt_keep = '0;
        next_state = state;
        next_state.rvalid = 1'b0;

        // error sources, bit 11 held 0
        err_set = ERROR_SRC & `MAIS_ERROR_VALID_MASK;
        evt_set = EVENT_SRC & state.event_enable[22:0] & `MAIS_EVENT_VALID_MASK;

        err_keep = state.error_cause;
        evt_keep = state.event_cause;

        // read returns cause, auto-clear when enabled
        if (cmd.read_error)
        begin
            next_state.rdata  = {9'h000, state.error_cause};
            next_state.rvalid = 1'b1;
            if (!CFG.auto_cause_reset_off)
                err_keep = '0;
        end
        if (cmd.read_event)
        begin
            next_state.rdata  = {9'h000, state.event_cause};
            next_state.rvalid = 1'b1;
            if (!CFG.auto_cause_reset_off)
                evt_keep = '0;
        end
        if (cmd.write_error)
            err_keep = w1c(state.error_cause, CMD_WDATA);
        if (cmd.write_event)
            evt_keep = w1c(state.event_cause, CMD_WDATA);
        if (cmd.write_enable)
            next_state.event_enable = CMD_WDATA & {15'h0000, 17'h1ffff};

        // new causes win over a same-cycle clear
        next_state.error_cause = err_keep | err_set;
        next_state.event_cause = evt_keep | evt_set;

        // stop flag clears by command, or by start when auto_stop_irq_reset is set
        if (cmd.stop_reset || (START_CMD && CFG.auto_stop_irq_reset))
            next_state.stop_flag = 1'b0;
        // stop flag set, blocked when prereg fixed and prereg_stop_irq_disable set
        if (STOP_EVENT && !(CFG.prereg_stop_irq_disable && PREREG_FIXED))
            next_state.stop_flag = 1'b1;
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            state              <= '0;
            state.event_enable <= `MAIS_ENABLE_RESET;
        end
        else if (CE)
        begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_summary;
        @(posedge CLK) disable iff (RST)
        SUMMARY_IRQ_REQUEST == (!CFG.irq_request_mask && (error_irq_flag || event_irq_flag ||
            (MAIN_STATUS[`MAIS_MSTS_STOP] && !CFG.stop_to_request_disable)));
    endproperty
    a_summary: assert property (p_summary) else $error("summary mismatch");

    property p_mask;
        @(posedge CLK) disable iff (RST)
        CFG.irq_request_mask |-> !SUMMARY_IRQ_REQUEST;
    endproperty
    a_mask: assert property (p_mask) else $error("masked request high");

    property p_stop_set;
        @(posedge CLK) disable iff (RST)
        CE && STOP_EVENT && !(CFG.prereg_stop_irq_disable && PREREG_FIXED)
        |=> MAIN_STATUS[`MAIS_MSTS_STOP];
    endproperty
    a_stop_set: assert property (p_stop_set) else $error("stop flag not set");

    property p_stop_block;
        @(posedge CLK) disable iff (RST)
        CE && !state.stop_flag && STOP_EVENT && CFG.prereg_stop_irq_disable && PREREG_FIXED
        |=> !state.stop_flag;
    endproperty
    a_stop_block: assert property (p_stop_block) else $error("stop set while blocked");

    property p_stop_auto;
        @(posedge CLK) disable iff (RST)
        CE && START_CMD && CFG.auto_stop_irq_reset && !STOP_EVENT |=> !state.stop_flag;
    endproperty
    a_stop_auto: assert property (p_stop_auto) else $error("start did not clear stop");

    property p_err_w1c;
        @(posedge CLK) disable iff (RST)
        CE && cmd.write_error && !cmd.read_error && ERROR_SRC == '0
        |=> state.error_cause == ($past(state.error_cause) & ~$past(CMD_WDATA[22:0]));
    endproperty
    a_err_w1c: assert property (p_err_w1c) else $error("error clear wrong");

    property p_evt_w1c;
        @(posedge CLK) disable iff (RST)
        CE && cmd.write_event && !cmd.read_event && EVENT_SRC == '0
        |=> state.event_cause == ($past(state.event_cause) & ~$past(CMD_WDATA[22:0]));
    endproperty
    a_evt_w1c: assert property (p_evt_w1c) else $error("event clear wrong");

    property p_rsvd;
        @(posedge CLK) disable iff (RST)
        !state.error_cause[`MAIS_ERROR_RSVD_BIT];
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved error bit set");

    property p_evt_gate;
        @(posedge CLK) disable iff (RST)
        CE && !state.event_cause[0] && !state.event_enable[0] && !cmd.write_enable
        |=> !state.event_cause[0];
    endproperty
    a_evt_gate: assert property (p_evt_gate) else $error("disabled event set");

    property p_auto_read;
        @(posedge CLK) disable iff (RST)
        CE && cmd.read_error && !CFG.auto_cause_reset_off && ERROR_SRC == '0
        |=> state.error_cause == '0 && CMD_RVALID;
    endproperty
    a_auto_read: assert property (p_auto_read) else $error("read did not clear");

    property p_read_evt;
        @(posedge CLK) disable iff (RST)
        CE && cmd.read_event && !CFG.auto_cause_reset_off && EVENT_SRC == '0
        |=> state.event_cause == '0 && CMD_RVALID;
    endproperty
    a_read_evt: assert property (p_read_evt) else $error("event read did not clear");

    property p_read_keep;
        @(posedge CLK) disable iff (RST)
        CE && cmd.read_event && CFG.auto_cause_reset_off
        |=> (state.event_cause & $past(state.event_cause)) == $past(state.event_cause);
    endproperty
    a_read_keep: assert property (p_read_keep) else $error("read cleared while off");

    property p_read_data;
        @(posedge CLK) disable iff (RST)
        CE && cmd.read_error |=> CMD_RDATA == {9'h000, $past(state.error_cause)};
    endproperty
    a_read_data: assert property (p_read_data) else $error("error read data wrong");

    property p_rvalid_one;
        @(posedge CLK) disable iff (RST)
        CE && !cmd.read_error && !cmd.read_event |=> !CMD_RVALID;
    endproperty
    a_rvalid_one: assert property (p_rvalid_one) else $error("read valid without read");

    property p_enable_wr;
        @(posedge CLK) disable iff (RST)
        CE && cmd.write_enable
        |=> state.event_enable == ($past(CMD_WDATA) & 32'h0001ffff);
    endproperty
    a_enable_wr: assert property (p_enable_wr) else $error("enable write wrong");

    property p_set_wins;
        @(posedge CLK) disable iff (RST)
        CE && ERROR_SRC[1] && cmd.write_error |=> state.error_cause[1];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("clear beat a new cause");

    property p_stop_clear;
        @(posedge CLK) disable iff (RST)
        CE && cmd.stop_reset && !STOP_EVENT |=> !state.stop_flag;
    endproperty
    a_stop_clear: assert property (p_stop_clear) else $error("stop reset ignored");

    property p_stop_hold;
        @(posedge CLK) disable iff (RST)
        CE && state.stop_flag && !cmd.stop_reset
        && !(START_CMD && CFG.auto_stop_irq_reset)
        |=> state.stop_flag;
    endproperty
    a_stop_hold: assert property (p_stop_hold) else $error("stop flag lost");

    property p_no_auto;
        @(posedge CLK) disable iff (RST)
        CE && START_CMD && !CFG.auto_stop_irq_reset && !cmd.stop_reset
        && state.stop_flag |=> state.stop_flag;
    endproperty
    a_no_auto: assert property (p_no_auto) else $error("start cleared stop flag");

    property p_err_cmp;
        @(posedge CLK) disable iff (RST)
        CE && ERROR_SRC[0] |=> state.error_cause[0];
    endproperty
    a_err_cmp: assert property (p_err_cmp) else $error("comparator error not set");

    property p_err_lim;
        @(posedge CLK) disable iff (RST)
        CE && ERROR_SRC[3] |=> state.error_cause[3];
    endproperty
    a_err_lim: assert property (p_err_lim) else $error("limit error not set");

    property p_evt_cmp;
        @(posedge CLK) disable iff (RST)
        CE && EVENT_SRC[5] && state.event_enable[5] |=> state.event_cause[5];
    endproperty
    a_evt_cmp: assert property (p_evt_cmp) else $error("enabled event not set");

    property p_evt_high;
        @(posedge CLK) disable iff (RST)
        state.event_cause[22:17] == 6'h00;
    endproperty
    a_evt_high: assert property (p_evt_high) else $error("undefined event bit set");

    property p_status_hi;
        @(posedge CLK) disable iff (RST)
        MAIN_STATUS[7:4] == 4'h0;
    endproperty
    a_status_hi: assert property (p_status_hi) else $error("status upper bits set");

    property p_stop_gate;
        @(posedge CLK) disable iff (RST)
        CFG.stop_to_request_disable && !error_irq_flag && !event_irq_flag
        |-> !SUMMARY_IRQ_REQUEST;
    endproperty
    a_stop_gate: assert property (p_stop_gate) else $error("stop raised request");

    c_stop: cover property (@(posedge CLK) disable iff (RST) STOP_EVENT ##1 SUMMARY_IRQ_REQUEST);
    c_err:  cover property (@(posedge CLK) disable iff (RST) error_irq_flag ##1 cmd.write_error);
    c_evt:  cover property (@(posedge CLK) disable iff (RST) event_irq_flag ##1 cmd.read_event);

endmodule

// >>> verification/mais_center_model.sv
// model of the network center relaying host commands to the axis
// assumes the command port of mais_top and one shared clock
`timescale 1ns/1ps

module mais_center_model
(
    // clock
    input  wire logic        clk,
    // command port
    output logic      [15:0] code,
    output logic             valid,
    output logic      [31:0] wdata,
    input  wire logic [31:0] rdata,
    input  wire logic        rvalid
);
    initial
    begin
        code  = 16'h0000;
        valid = 1'b0;
        wdata = 32'h00000000;
    end

    // one command, answer taken half a cycle after the taking edge
    task automatic send(input logic [15:0] c, input logic [31:0] d,
                        output logic [31:0] rd, output logic got);
        @(negedge clk);
        code  = c;
        wdata = d;
        valid = 1'b1;
        @(negedge clk);
        got   = rvalid;
        rd    = rdata;
        valid = 1'b0;
        // released lines never show the last value
        code  = ~c;
        wdata = ~d;
    endtask
endmodule

// >>> verification/tb_top.sv
// self-checking bench of the axis interrupt status block
// assumes mais_top, mais_center_model and a 40 MHz clock
`timescale 1ns/1ps
`include "mais_regs.svh"

module tb_top
    import mais_pkg::*;
;
    logic              clk = 1'b0;
    logic              rst = 1'b1;
    logic              ce = 1'b1;
    logic       [15:0] code;
    logic              valid;
    logic       [31:0] wdata;
    logic       [31:0] rdata;
    logic              rvalid;
    mais_cfg_s         cfg = '0;
    logic              stop_ev = 1'b0;
    logic              prefix = 1'b0;
    logic              start = 1'b0;
    logic       [22:0] esrc = '0;
    logic       [22:0] vsrc = '0;
    logic       [7:0]  status;
    logic              summary;
    logic       [31:0] rd;
    int                err_count = 0;
    int                checks_done = 0;

    always #12.5 clk = ~clk;

    mais_top mais_top_inst (.CLK(clk), .RST(rst), .CE(ce), .CMD_CODE(code),
        .CMD_VALID(valid), .CMD_WDATA(wdata), .CMD_RDATA(rdata), .CMD_RVALID(rvalid),
        .CFG(cfg), .STOP_EVENT(stop_ev), .PREREG_FIXED(prefix), .START_CMD(start),
        .ERROR_SRC(esrc), .EVENT_SRC(vsrc), .MAIN_STATUS(status),
        .SUMMARY_IRQ_REQUEST(summary));

    mais_center_model mais_center_model_inst (.clk(clk), .code(code), .valid(valid),
        .wdata(wdata), .rdata(rdata), .rvalid(rvalid));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_status(input logic [7:0] exp);
        chk({23'h0, summary, status}, {23'h0, exp[0], exp});
    endtask

    task automatic xfer(input logic [15:0] c, input logic [31:0] d);
        logic got;
        logic is_rd;
        is_rd = (c == `MAIS_CMD_READ_ERROR) || (c == `MAIS_CMD_READ_EVENT);
        mais_center_model_inst.send(c, d, rd, got);
        // read pulse only for reads
        chk({31'h0, got}, {31'h0, is_rd});
    endtask

    task automatic pulse(input logic s, input logic st, input logic [22:0] e,
                         input logic [22:0] v);
        @(negedge clk);
        {stop_ev, start, esrc, vsrc} = {s, st, e, v};
        @(negedge clk);
        {stop_ev, start, esrc, vsrc} = '0;
    endtask

    task automatic t_stop();
        pulse(1'b1, 1'b0, '0, '0);
        chk_status(8'h03);
        @(negedge clk);
        cfg.irq_request_mask = 1'b1;
        #1 chk_status(8'h02);
        @(negedge clk);
        cfg = '0;
        cfg.stop_to_request_disable = 1'b1;
        #1 chk_status(8'h02);
        @(negedge clk);
        cfg = '0;
        xfer(`MAIS_CMD_STOP_IRQ_RESET, 32'h0);
        chk_status(8'h00);
        ce = 1'b0;
        pulse(1'b1, 1'b0, '0, '0);
        ce = 1'b1;
        chk_status(8'h00);
        prefix = 1'b1;
        cfg.prereg_stop_irq_disable = 1'b1;
        pulse(1'b1, 1'b0, '0, '0);
        chk_status(8'h00);
        cfg = '0;
        pulse(1'b1, 1'b0, '0, '0);
        chk_status(8'h03);
        pulse(1'b0, 1'b1, '0, '0);
        chk_status(8'h03);
        prefix = 1'b0;
        cfg.auto_stop_irq_reset = 1'b1;
        pulse(1'b0, 1'b1, '0, '0);
        chk_status(8'h00);
        cfg = '0;
        $display("test stop done");
    endtask

    task automatic t_error();
        for (int i = 0; i < 23; i++)
        begin
            pulse(1'b0, 1'b0, 23'h1 << i, '0);
            chk_status(i == 11 ? 8'h00 : 8'h05);
            xfer(`MAIS_CMD_READ_ERROR, 32'h0);
            chk(rd, i == 11 ? 32'h0 : 32'h1 << i);
            chk_status(8'h00);
        end
        $display("test error done");
    endtask

    task automatic t_event();
        pulse(1'b0, 1'b0, '0, '1);
        chk_status(8'h00);
        xfer(`MAIS_CMD_WRITE_ENABLE, 32'hffffffff);
        for (int i = 0; i < 23; i++)
        begin
            pulse(1'b0, 1'b0, '0, 23'h1 << i);
            chk_status(i < 17 ? 8'h09 : 8'h00);
            xfer(`MAIS_CMD_READ_EVENT, 32'h0);
            chk(rd, i < 17 ? 32'h1 << i : 32'h0);
        end
        xfer(`MAIS_CMD_WRITE_ENABLE, 32'h00000005);
        pulse(1'b0, 1'b0, '0, '1);
        xfer(`MAIS_CMD_READ_EVENT, 32'h0);
        chk(rd, 32'h00000005);
        $display("test event done");
    endtask

    task automatic t_w1c();
        cfg.auto_cause_reset_off = 1'b1;
        pulse(1'b0, 1'b0, '1, '1);
        xfer(`MAIS_CMD_READ_ERROR, 32'h0);
        xfer(`MAIS_CMD_READ_ERROR, 32'h0);
        chk(rd, 32'h007ff7ff);
        chk_status(8'h0d);
        xfer(`MAIS_CMD_WRITE_ERROR, 32'h0000000f);
        xfer(`MAIS_CMD_READ_ERROR, 32'h0);
        chk(rd, 32'h007ff7f0);
        xfer(`MAIS_CMD_WRITE_EVENT, 32'h00000004);
        xfer(`MAIS_CMD_READ_EVENT, 32'h0);
        chk(rd, 32'h00000001);
        xfer(`MAIS_CMD_WRITE_ERROR, 32'hffffffff);
        chk_status(8'h09);
        xfer(`MAIS_CMD_WRITE_EVENT, 32'hffffffff);
        chk_status(8'h00);
        // new cause wins over a same-cycle clear
        fork
            pulse(1'b0, 1'b0, 23'h000002, '0);
            xfer(`MAIS_CMD_WRITE_ERROR, 32'hffffffff);
        join
        xfer(`MAIS_CMD_READ_ERROR, 32'h0);
        chk(rd, 32'h00000002);
        $display("test w1c done");
    endtask

    task automatic t_reset();
        pulse(1'b1, 1'b0, '1, '1);
        chk_status(8'h0f);
        @(negedge clk);
        rst = 1'b1;
        #1 chk_status(8'h00);
        chk(rdata, 32'h0);
        @(negedge clk);
        rst = 1'b0;
        pulse(1'b0, 1'b0, '0, '1);
        chk_status(8'h00);
        $display("test reset done");
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial
    begin
        repeat (3) @(negedge clk);
        rst = 1'b0;
        chk_status(8'h00);
        t_stop();
        t_error();
        t_event();
        t_w1c();
        t_reset();
        tally_and_finish();
    end

    // cut a hang short
    initial
    begin
        repeat (20000) @(posedge clk);
        err_count++;
        tally_and_finish();
    end
endmodule
